// [segmented_local_bus_pkg.sv]
/*
  Shared constants and types for the segmented local bus block.
  Assumes a single clock domain and a 32-bit AXI4-Lite register bus.
*/
package segmented_local_bus_pkg;
  // Bus geometry
  localparam int SEGS = 4;
  localparam int WORD_W = 128;
  localparam int EMPTY_W = 4;
  localparam int ADDR_W = 8;
  // Transmit FIFO shape
  localparam int FIFO_DEPTH = 16;
  localparam int PTR_W = 4;
  localparam int CNT_W = 5;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] CLEAR_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] ENABLE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] THRESH_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] FILL_OFS = 8'h10;
  // Status bit positions
  localparam int ST_RX_OVR = 0;
  localparam int ST_TX_OVR = 1;
  localparam int ST_RX_BAD = 2;
  localparam int ST_W = 3;
  // Reset values
  localparam logic [CNT_W-1:0] THRESH_RST = 5'h0C;
  localparam logic [ST_W-1:0] ENABLE_RST = 3'h0;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One transmit bus beat across all segments
  typedef struct packed {
    logic [SEGS-1:0] valid;
    logic [SEGS-1:0] last;
    logic [SEGS-1:0][WORD_W-1:0] word;
  } tx_beat_t;
endpackage : segmented_local_bus_pkg

// [tx_fifo_if.sv]
/*
  Carrier between the bus block and its transmit FIFO.
  Assumes segmented_local_bus_pkg is compiled first.
*/
interface tx_fifo_if;
  import segmented_local_bus_pkg::*;
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic [CNT_W-1:0] fill;
  tx_beat_t in_beat;
  tx_beat_t out_beat;
  modport store (input push, input pop, input in_beat, output full, output empty, output fill, output out_beat);
  modport user (output push, output pop, output in_beat, input full, input empty, input fill, input out_beat);
endinterface : tx_fifo_if

// [rx_seg_qualify.sv]
/*
  One receive segment output stage: registers and qualifies the
  segment's marker, error and empty count. Assumes one clock.
*/
module rx_seg_qualify
  import segmented_local_bus_pkg::*;
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  input logic clk_en,
  // Segment from the link side
  input logic in_valid,
  input logic in_last,
  input logic in_bad,
  input logic [EMPTY_W-1:0] in_empty,
  input logic [WORD_W-1:0] in_word,
  // Segment to user logic
  output logic out_valid,
  output logic out_last,
  output logic out_bad,
  output logic [EMPTY_W-1:0] out_empty,
  output logic [WORD_W-1:0] out_word
);
  typedef struct packed {
    logic valid;
    logic last;
    logic bad;
    logic [EMPTY_W-1:0] empty;
    logic [WORD_W-1:0] word;
  } seg_state_t;

  seg_state_t st_reg;
  seg_state_t st_next;

  // Qualifiers are forced to zero outside their valid cycles so stale values never leak
  always_comb
  begin
    st_next = st_reg;
    st_next.valid = in_valid;
    st_next.last = in_valid && in_last;
    st_next.bad = in_valid && in_last && in_bad;
    st_next.empty = '0;
    if (in_valid && in_last)
    begin
      st_next.empty = in_empty;
      if (in_bad)
        st_next.empty = {in_empty[EMPTY_W-1], 3'h0};
    end
    if (in_valid)
      st_next.word = in_word;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= '0;
    else if (clk_en)
      st_reg <= st_next;
  end

  assign out_valid = st_reg.valid;
  assign out_last = st_reg.last;
  assign out_bad = st_reg.bad;
  assign out_empty = st_reg.empty;
  assign out_word = st_reg.word;
endmodule : rx_seg_qualify

// [tx_fifo.sv]
/*
  Transmit FIFO holding whole bus beats.
  Assumes the writer never pushes when full and pop is ignored when empty.
*/
module tx_fifo
  import segmented_local_bus_pkg::*;
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  input logic clk_en,
  // Store side
  tx_fifo_if.store fifo
);
  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
  } fifo_state_t;

  fifo_state_t st_reg;
  fifo_state_t st_next;
  tx_beat_t mem [FIFO_DEPTH];
  logic do_push;
  logic do_pop;

  assign do_push = fifo.push && !fifo.full;
  assign do_pop = fifo.pop && !fifo.empty;

  // Pointer and count update
  always_comb
  begin
    st_next = st_reg;
    if (do_push)
      st_next.wr_ptr = st_reg.wr_ptr + 4'h1;
    if (do_pop)
      st_next.rd_ptr = st_reg.rd_ptr + 4'h1;
    if (do_push && !do_pop)
      st_next.count = st_reg.count + 5'h01;
    else if (do_pop && !do_push)
      st_next.count = st_reg.count - 5'h01;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= '0;
    else if (clk_en)
      st_reg <= st_next;
  end

  // Storage needs no reset; the count guards every read
  always_ff @(posedge aclk)
  begin
    if (clk_en && do_push)
      mem[st_reg.wr_ptr] <= fifo.in_beat;
  end

  assign fifo.full = (st_reg.count == 5'h10);
  assign fifo.empty = (st_reg.count == 5'h00);
  assign fifo.fill = st_reg.count;
  assign fifo.out_beat = mem[st_reg.rd_ptr];
endmodule : tx_fifo

// [segmented_packet_user_bus.sv]
/*
  Segmented local packet bus between the protocol core and user logic:
  receive qualifiers, transmit back-pressure with FIFO, status interrupts.
  Assumes one clock, synchronous active-low reset and an AXI4-Lite master.
*/
// Operation
// - Receive last flag marks a segment's final transfer, only with its valid.
// - Receive bad flag is one for an errored packet, zero otherwise.
// - Receive bad flag means something only when valid and last are both high.
// - On the last transfer each segment carries a four-bit empty byte count.
// - Empty count means something only when valid and last are both high.
// - With bad and valid high the empty count's low three bits read 000.
// - Transmit accept output is one while the transmit path can take data.
// - Accept comes from comparing transmit FIFO fill against a threshold.
// - Transmit overrun flags user data sent against withdrawn accept.
// - Each transmit segment word is captured whenever its valid is high; here a beat pushed while the FIFO is full is dropped.
// - A receive segment's valid qualifies all its other signals.
// - Receive overrun flags a local bus too slow for incoming traffic.
module segmented_packet_user_bus
  import segmented_local_bus_pkg::*;
(
  // Clock, enable and reset
  input logic aclk,
  input logic aresetn,
  input logic clk_en,
  // Register bus
  input logic [segmented_local_bus_pkg::ADDR_W-1:0] s_axi_awaddr,
  input logic s_axi_awvalid,
  output logic s_axi_awready,
  input logic [31:0] s_axi_wdata,
  input logic [3:0] s_axi_wstrb,
  input logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input logic s_axi_bready,
  input logic [segmented_local_bus_pkg::ADDR_W-1:0] s_axi_araddr,
  input logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input logic s_axi_rready,
  // Interrupt
  output logic irq,
  // Receive beats from the protocol core
  input logic [segmented_local_bus_pkg::SEGS-1:0] link_rx_valid,
  input logic [segmented_local_bus_pkg::SEGS-1:0] link_rx_last,
  input logic [segmented_local_bus_pkg::SEGS-1:0] link_rx_bad,
  input logic [segmented_local_bus_pkg::SEGS-1:0][segmented_local_bus_pkg::EMPTY_W-1:0] link_rx_empty,
  input logic [segmented_local_bus_pkg::SEGS-1:0][segmented_local_bus_pkg::WORD_W-1:0] link_rx_word,
  input logic link_rx_extra,
  // Receive user bus
  output logic [segmented_local_bus_pkg::SEGS-1:0] rx_seg_valid,
  output logic [segmented_local_bus_pkg::SEGS-1:0] rx_seg_last,
  output logic [segmented_local_bus_pkg::SEGS-1:0] rx_seg_bad_packet,
  output logic [segmented_local_bus_pkg::SEGS-1:0][segmented_local_bus_pkg::EMPTY_W-1:0] rx_seg_empty_bytes,
  output logic [segmented_local_bus_pkg::SEGS-1:0][segmented_local_bus_pkg::WORD_W-1:0] rx_seg_word,
  output logic rx_bus_overrun,
  // Transmit user bus
  input logic [segmented_local_bus_pkg::SEGS-1:0] tx_seg_valid,
  input logic [segmented_local_bus_pkg::SEGS-1:0] tx_seg_last,
  input logic [segmented_local_bus_pkg::SEGS-1:0][segmented_local_bus_pkg::WORD_W-1:0] tx_seg_word,
  output logic tx_accept_ok,
  output logic tx_bus_overrun,
  // Transmit beats toward the protocol core
  output logic link_tx_valid,
  input logic link_tx_ready,
  output logic [segmented_local_bus_pkg::SEGS-1:0] link_tx_seg_valid,
  output logic [segmented_local_bus_pkg::SEGS-1:0] link_tx_last,
  output logic [segmented_local_bus_pkg::SEGS-1:0][segmented_local_bus_pkg::WORD_W-1:0] link_tx_word
);
  import segmented_local_bus_pkg::*;

  typedef struct packed {
    logic rx_ovr;
    logic tx_ovr;
    logic rdy;
    logic [ST_W-1:0] status;
    logic [ST_W-1:0] enable;
    logic [CNT_W-1:0] thresh;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic wstrb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  localparam state_t RESET_ST = '{rdy: 1'b1, thresh: THRESH_RST, enable: ENABLE_RST, default: '0};

  state_t st_reg;
  state_t st_next;
  logic tx_push;
  tx_fifo_if fifo ();

  ////////////////////////////////////////////////////////////////////////
  // Receive segments, segment 0 first in byte order
  for (genvar i = 0; i < SEGS; i++)
  begin : g_rx
    rx_seg_qualify u_seg (
      .aclk(aclk),
      .aresetn(aresetn),
      .clk_en(clk_en),
      .in_valid(link_rx_valid[i]),
      .in_last(link_rx_last[i]),
      .in_bad(link_rx_bad[i]),
      .in_empty(link_rx_empty[i]),
      .in_word(link_rx_word[i]),
      .out_valid(rx_seg_valid[i]),
      .out_last(rx_seg_last[i]),
      .out_bad(rx_seg_bad_packet[i]),
      .out_empty(rx_seg_empty_bytes[i]),
      .out_word(rx_seg_word[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit FIFO; a beat is stored only if there is room, so data pushed while the FIFO is full is lost
  assign tx_push = |tx_seg_valid;
  assign fifo.push = tx_push && !fifo.full;
  assign fifo.in_beat = '{valid: tx_seg_valid, last: tx_seg_last, word: tx_seg_word};
  assign fifo.pop = link_tx_ready && clk_en;

  tx_fifo u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .clk_en(clk_en),
    .fifo(fifo)
  );

  assign link_tx_valid = !fifo.empty && clk_en;
  assign link_tx_seg_valid = fifo.out_beat.valid;
  assign link_tx_last = fifo.out_beat.last;
  assign link_tx_word = fifo.out_beat.word;

  ////////////////////////////////////////////////////////////////////////
  // Bus handshakes; the ready outputs are gated by the enable so no address or data beat is taken while state is frozen
  assign s_axi_awready = clk_en && !st_reg.aw_got && !st_reg.bvalid;
  assign s_axi_wready = clk_en && !st_reg.w_got && !st_reg.bvalid;
  assign s_axi_arready = clk_en && !st_reg.rvalid;
  assign s_axi_bvalid = st_reg.bvalid;
  assign s_axi_bresp = st_reg.bresp;
  assign s_axi_rvalid = st_reg.rvalid;
  assign s_axi_rdata = st_reg.rdata;
  assign s_axi_rresp = st_reg.rresp;
  assign irq = |(st_reg.status & st_reg.enable);
  assign tx_accept_ok = st_reg.rdy;
  assign rx_bus_overrun = st_reg.rx_ovr;
  assign tx_bus_overrun = st_reg.tx_ovr;

  // Next-state logic: events, registers and the bus slave
  always_comb
  begin
    logic [ST_W-1:0] ev;
    logic [ST_W-1:0] clr;
    ev = '0;
    clr = '0;
    st_next = st_reg;
    ev[ST_RX_OVR] = link_rx_extra;
    ev[ST_TX_OVR] = tx_push && (!st_reg.rdy || fifo.full);
    ev[ST_RX_BAD] = |rx_seg_bad_packet;
    st_next.rx_ovr = ev[ST_RX_OVR];
    st_next.tx_ovr = ev[ST_TX_OVR];
    // Ready lags fill by a cycle; threshold below depth leaves headroom for it
    st_next.rdy = (fifo.fill < st_reg.thresh);
    if (st_reg.bvalid && s_axi_bready)
      st_next.bvalid = 1'b0;
    if (st_reg.rvalid && s_axi_rready)
      st_next.rvalid = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      st_next.aw_got = 1'b1;
      st_next.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata;
      st_next.wstrb0 = s_axi_wstrb[0];
    end
    // Write commits once both address and data are held
    if (st_reg.aw_got && st_reg.w_got)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = RESP_OKAY;
      unique case (st_reg.awaddr)
        CLEAR_OFS:
          if (st_reg.wstrb0)
            clr = st_reg.wdata[ST_W-1:0];
        ENABLE_OFS:
          if (st_reg.wstrb0)
            st_next.enable = st_reg.wdata[ST_W-1:0];
        THRESH_OFS:
          if (st_reg.wstrb0)
            st_next.thresh = st_reg.wdata[CNT_W-1:0];
        STATUS_OFS, FILL_OFS:
          st_next.bresp = RESP_OKAY;
        default:
          st_next.bresp = RESP_SLVERR;
      endcase
    end
    // Set wins over a clear landing in the same cycle
    st_next.status = (st_reg.status & ~clr) | ev;
    if (s_axi_arvalid && s_axi_arready)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = RESP_OKAY;
      st_next.rdata = '0;
      unique case (s_axi_araddr)
        STATUS_OFS:
          st_next.rdata[ST_W-1:0] = st_reg.status;
        ENABLE_OFS:
          st_next.rdata[ST_W-1:0] = st_reg.enable;
        THRESH_OFS:
          st_next.rdata[CNT_W-1:0] = st_reg.thresh;
        FILL_OFS:
          st_next.rdata[CNT_W-1:0] = fifo.fill;
        CLEAR_OFS:
          st_next.rresp = RESP_OKAY;
        default:
          st_next.rresp = RESP_SLVERR;
      endcase
    end
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= RESET_ST;
    else if (clk_en)
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_last_qualified: assert property ((rx_seg_last & ~rx_seg_valid) == '0)
    else $error("receive last without valid");
  chk_bad_follows: assert property (clk_en && link_rx_valid[0] && link_rx_last[0]
    |=> rx_seg_bad_packet[0] == $past(link_rx_bad[0]))
    else $error("receive bad flag does not follow the packet");
  chk_bad_qualified: assert property ((rx_seg_bad_packet & ~(rx_seg_valid & rx_seg_last)) == '0)
    else $error("receive bad flag outside a last transfer");
  chk_empty_passes: assert property (clk_en && link_rx_valid[1] && link_rx_last[1] && !link_rx_bad[1]
    |=> rx_seg_empty_bytes[1] == $past(link_rx_empty[1]))
    else $error("empty count not delivered");
  chk_empty_quiet: assert property (!(rx_seg_valid[2] && rx_seg_last[2])
    |-> rx_seg_empty_bytes[2] == 4'h0)
    else $error("empty count outside a last transfer");
  chk_empty_on_bad: assert property (rx_seg_bad_packet[3] && rx_seg_valid[3]
    |-> rx_seg_empty_bytes[3][2:0] == 3'h0)
    else $error("empty low bits not zero on error");
  chk_ready_fill: assert property (clk_en |=> tx_accept_ok == ($past(fifo.fill) < $past(st_reg.thresh)))
    else $error("accept does not track fill threshold");
  chk_ready_drops: assert property (clk_en && fifo.fill >= st_reg.thresh |=> !tx_accept_ok)
    else $error("accept stays high above threshold");
  chk_tx_overrun: assert property (clk_en && tx_push && !tx_accept_ok |=> tx_bus_overrun)
    else $error("overrun not flagged");
  chk_tx_capture: assert property (clk_en && tx_push && fifo.empty
    |=> link_tx_seg_valid == $past(tx_seg_valid) && link_tx_word == $past(tx_seg_word))
    else $error("transmit word not captured");
  chk_rx_order: assert property (clk_en && link_rx_valid == 4'hF
    |=> rx_seg_word == $past(link_rx_word) && rx_seg_valid == 4'hF)
    else $error("receive segments out of place");
  chk_rx_overrun: assert property (clk_en && link_rx_extra |=> rx_bus_overrun[*1] ##0 st_reg.status[ST_RX_OVR])
    else $error("receive overrun not flagged");
  // Overrun is raised only by a real violation, never by a push that accept allowed while the FIFO had room
  chk_overrun_only: assert property (clk_en && tx_push && tx_accept_ok && !fifo.full |=> !tx_bus_overrun)
    else $error("overrun flagged on a legal push");
  // The transmit overrun status bit is sticky: it stays set until a write commits
  chk_status_sticky: assert property (clk_en && st_reg.status[ST_TX_OVR] && !(st_reg.aw_got && st_reg.w_got)
    |=> st_reg.status[ST_TX_OVR])
    else $error("overrun status lost without a clear");
  // A committed clear empties its bit when no new event lands with it
  chk_clear_lands: assert property (clk_en && st_reg.aw_got && st_reg.w_got && st_reg.awaddr == CLEAR_OFS
    && st_reg.wstrb0 && st_reg.wdata[ST_RX_OVR] && !link_rx_extra |=> !st_reg.status[ST_RX_OVR])
    else $error("status clear did not land");
  // Register bus answers one edge after the request is complete
  chk_write_answer: assert property (clk_en && st_reg.aw_got && st_reg.w_got |=> s_axi_bvalid)
    else $error("write response missing");
  chk_read_answer: assert property (clk_en && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response missing");

  cov_bad_packet: cover property (rx_seg_bad_packet[0] && rx_seg_empty_bytes[0][3]);
  cov_backpressure: cover property (tx_accept_ok ##1 !tx_accept_ok ##[1:40] tx_accept_ok);
  cov_tx_overrun: cover property (tx_bus_overrun && irq);
  cov_link_stall: cover property (link_tx_valid && !link_tx_ready ##1 link_tx_valid && link_tx_ready);
  // A push against withdrawn accept that still finds room
  cov_rude_push: cover property (tx_push && !tx_accept_ok && !fifo.full);
endmodule : segmented_packet_user_bus

// [user_pkt_model.sv]
/*
  User packet logic model that feeds the transmit bus.
  Assumes one clock and the block's registered accept output.
*/
module user_pkt_model
(
  // Clock and reset
  input logic aclk,
  input logic aresetn,
  // Control from the bench
  input logic want,
  input logic rude,
  input logic tx_accept_ok,
  // Transmit bus toward the block
  output segmented_local_bus_pkg::tx_beat_t beat,
  output logic [7:0] pushed
);
  import segmented_local_bus_pkg::*;
  //////////////////////////////////////////////////////////////////////
  // Offer a beat while accept stands now, or whenever rude is high; a registered offer would be a cycle stale
  always_comb
  begin
    beat.valid = (rude || (want && tx_accept_ok)) ? 4'hF : 4'h0;
    beat.last = (pushed[1:0] == 2'h3) ? 4'h8 : 4'h0;
    for (int s = 0; s < SEGS; s++)
    begin
      // Idle words are inverted so a stale capture cannot pass
      beat.word[s] = {112'h0, 8'(s), pushed};
      if (beat.valid == 4'h0)
        beat.word[s] = ~beat.word[s];
    end
  end

  // Count beats offered; rude pushes ignore accept on purpose
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pushed <= 8'h00;
    else if (|beat.valid)
      pushed <= pushed + 8'h01;
  end
endmodule : user_pkt_model

// [segmented_packet_user_bus_tb.sv]
/*
  Self-checking bench for the segmented bus block.
  Assumes the model of user logic and AXI4-Lite register access.
*/
module segmented_packet_user_bus_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import segmented_local_bus_pkg::*;
  typedef struct packed {
    logic [3:0] v, l, b;
    logic [15:0] e;
    logic [3:0] xl, xb;
    logic [15:0] xe;
  } rx_row_t;
  // Receive cases: valid, last, bad, empty, then expected outputs
  rx_row_t rows [5] = '{
    '{4'hF, 4'hF, 4'h0, 16'h5555, 4'hF, 4'h0, 16'h5555},
    '{4'hF, 4'hF, 4'hF, 16'hDDDD, 4'hF, 4'hF, 16'h8888},
    '{4'h5, 4'hF, 4'hF, 16'hFFFF, 4'h5, 4'h5, 16'h0808},
    '{4'hF, 4'h3, 4'h0, 16'h1234, 4'h3, 4'h0, 16'h0034},
    '{4'h0, 4'hF, 4'hF, 16'hFFFF, 4'h0, 4'h0, 16'h0000}};
  logic [7:0] ra [5] = '{STATUS_OFS, ENABLE_OFS, THRESH_OFS, FILL_OFS, 8'h14};
  logic [31:0] rv [5] = '{32'h0, 32'h0, 32'(THRESH_RST), 32'h0, 32'h0};
  logic [1:0] rr [5] = '{RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_OKAY, RESP_SLVERR};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic want = 1'b0, rude = 1'b0, extra = 1'b0, rdy = 1'b0, ce = 1'b1;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, pushed;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, irq, rx_ovr, acc, tx_ovr, ltx_ok;
  logic [1:0] bresp, rresp, resp;
  logic [3:0] lrx_v = 4'h0, lrx_l = 4'h0, lrx_b = 4'h0, rxv, rxl, rxb, ltx_v, ltx_l;
  logic [15:0] lrx_e = 16'h0, rxe;
  logic [SEGS-1:0][WORD_W-1:0] lrx_w = '0, rxw, ltx_w;
  logic [WORD_W-1:0] ew [SEGS] = '{default: '0};
  tx_beat_t beat;
  int err_count = 0, comparisons = 0, ovr_n = 0, n, k;

  segmented_packet_user_bus DUT (.aclk(aclk), .aresetn(aresetn), .clk_en(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq(irq), .link_rx_valid(lrx_v), .link_rx_last(lrx_l), .link_rx_bad(lrx_b),
    .link_rx_empty(lrx_e), .link_rx_word(lrx_w), .link_rx_extra(extra),
    .rx_seg_valid(rxv), .rx_seg_last(rxl), .rx_seg_bad_packet(rxb),
    .rx_seg_empty_bytes(rxe), .rx_seg_word(rxw), .rx_bus_overrun(rx_ovr),
    .tx_seg_valid(beat.valid), .tx_seg_last(beat.last), .tx_seg_word(beat.word),
    .tx_accept_ok(acc), .tx_bus_overrun(tx_ovr), .link_tx_valid(ltx_ok),
    .link_tx_ready(rdy), .link_tx_seg_valid(ltx_v), .link_tx_last(ltx_l), .link_tx_word(ltx_w));

  user_pkt_model model (.aclk(aclk), .aresetn(aresetn), .want(want), .rude(rude),
    .tx_accept_ok(acc), .beat(beat), .pushed(pushed));

  //////////////////////////////////////////////////////////////////////
  // Clock, overrun pulse counter and watchdog
  initial
  begin
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk)
    if (tx_ovr === 1'b1)
      ovr_n++;
  initial
  begin
    #500000;
    err_count++;
    results();
  end

  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  task automatic chk_word(input string nm, input logic [127:0] e, input logic [127:0] g);
    comparisons++;
    if (g !== e)
    begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask : chk_word

  // Write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic aw, w, b;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    b = 1'b0;
    while (!b && n < 50)
    begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      resp = bresp;
      @(posedge aclk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
      n++;
    end
    // Bready stays high between writes so it is never driven twice in one step
    if (n == 50)
      err_count++;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    logic ar, r;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    r = 1'b0;
    while (!r && n < 50)
    begin
      @(negedge aclk);
      ar = arvalid && arready;
      r = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar)
        arvalid <= 1'b0;
      n++;
    end
    // Rready stays high between reads for the same reason
    if (n == 50)
      err_count++;
  endtask : rd

  task results;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("accept", 32'h1, acc);
    @(posedge aclk);
    for (k = 0; k < 5; k++)
    begin
      rd(ra[k]);
      chk("reset rdata", rv[k], d);
      chk("rresp", rr[k], resp);
    end
    wr(THRESH_OFS, 32'h3);
    rd(THRESH_OFS);
    chk("threshold", 32'h3, d);
    wr(THRESH_OFS, 32'(THRESH_RST));
    wr(8'h14, 32'hFF);
    chk("bresp", RESP_SLVERR, resp);
    $display("test reset done");
    // Table of receive cases
    for (int i = 0; i < 5; i++)
    begin
      lrx_v <= rows[i].v;
      lrx_l <= rows[i].l;
      lrx_b <= rows[i].b;
      lrx_e <= rows[i].e;
      for (int s = 0; s < SEGS; s++)
      begin
        lrx_w[s] <= {112'h0, 8'(s), 8'(i + 1)};
        if (rows[i].v[s])
          ew[s] = {112'h0, 8'(s), 8'(i + 1)};
      end
      @(posedge aclk);
      @(negedge aclk);
      chk("rx valid", rows[i].v, rxv);
      chk("rx last", rows[i].xl, rxl);
      chk("rx bad", rows[i].xb, rxb);
      chk("rx empty", rows[i].xe, rxe);
      for (int s = 0; s < SEGS; s++)
        chk_word("rx word", ew[s], rxw[s]);
      @(posedge aclk);
    end
    lrx_v <= 4'h0;
    extra <= 1'b1;
    @(posedge aclk);
    extra <= 1'b0;
    @(negedge aclk);
    chk("rx overrun", 32'h1, rx_ovr);
    @(negedge aclk);
    chk("rx overrun", 32'h0, rx_ovr);
    @(posedge aclk);
    // Enable low: an offered receive beat must not be taken
    ce <= 1'b0;
    lrx_v <= 4'hF;
    repeat (2) @(posedge aclk);
    lrx_v <= 4'h0;
    ce <= 1'b1;
    @(negedge aclk);
    chk("frozen rx valid", 32'h0, rxv);
    @(posedge aclk);
    $display("test rx done");
    rd(STATUS_OFS);
    chk("status", 32'h5, d);
    chk("irq", 32'h0, irq);
    wr(ENABLE_OFS, 32'h1);
    @(negedge aclk);
    chk("irq", 32'h1, irq);
    @(posedge aclk);
    wr(CLEAR_OFS, 32'h5);
    repeat (2) @(posedge aclk);
    rd(STATUS_OFS);
    chk("status", 32'h0, d);
    chk("irq", 32'h0, irq);
    $display("test irq done");
    // Fill with the far side stalled until accept withdraws
    wr(ENABLE_OFS, 32'h2);
    want <= 1'b1;
    n = 0;
    while (acc !== 1'b0 && n < 100)
    begin
      @(negedge aclk);
      n++;
    end
    @(posedge aclk);
    want <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("tx overrun count", 32'h0, ovr_n);
    chk("accept", 32'h0, acc);
    // Accept lags fill by one cycle, so one beat beyond the threshold gets in
    chk("fill at stop", 32'(THRESH_RST) + 32'h1, 32'(pushed));
    rd(FILL_OFS);
    chk("fill", 32'(pushed), d);
    rude <= 1'b1;
    @(posedge aclk);
    rude <= 1'b0;
    repeat (3) @(posedge aclk);
    chk("tx overrun count", 32'h1, ovr_n);
    chk("irq", 32'h1, irq);
    // Drain and compare every beat in order
    rdy <= 1'b1;
    k = 0;
    n = 0;
    while (k < int'(pushed) && n < 100)
    begin
      @(negedge aclk);
      n++;
      if (ltx_ok === 1'b1)
      begin
        for (int s = 0; s < SEGS; s++)
          chk_word("tx word", {112'h0, 8'(s), 8'(k)}, ltx_w[s]);
        chk("tx valid", 32'hF, ltx_v);
        chk("tx last", (k % 4 == 3) ? 32'h8 : 32'h0, ltx_l);
        k++;
      end
    end
    @(posedge aclk);
    rdy <= 1'b0;
    chk("drained", 32'(pushed), k);
    repeat (2) @(posedge aclk);
    chk("accept", 32'h1, acc);
    rd(FILL_OFS);
    chk("fill", 32'h0, d);
    $display("test tx done");
    // Mid-run reset: threshold, status and interrupt return to reset values
    wr(THRESH_OFS, 32'h5);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk("accept after reset", 32'h1, acc);
    chk("irq after reset", 32'h0, irq);
    @(posedge aclk);
    rd(THRESH_OFS);
    chk("threshold after reset", 32'(THRESH_RST), d);
    rd(STATUS_OFS);
    chk("status after reset", 32'h0, d);
    $display("test mid-run reset done");
    results();
  end
endmodule : segmented_packet_user_bus_tb
